// ==== hdl/hpc_cfg_reader.sv ====
// Serial configuration memory reader that fetches vendor and product identifiers.
module hpc_cfg_reader
	import hpc_pkg::*;
#(
	parameter int HALF_CYC = CFG_HALF_CYC
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic start,
	input  wire logic mem_data_in,
	output logic      mem_clock_out,
	output logic      mem_clock_oe,
	output logic      mem_data_out,
	output logic      mem_data_oe,
	output hpc_ids_t  ids,
	output logic      done
);

	typedef enum logic [2:0] {RD_IDLE, RD_START, RD_BITS, RD_STOP, RD_END} hpc_rd_state_t;

	typedef struct packed {
		hpc_rd_state_t st;
		logic [15:0]   tick;
		logic [5:0]    nbit;
		logic [1:0]    phase;
		logic          d1;
		logic          d2;
		logic          clk_o;
		logic          clk_oe;
		logic          dat_o;
		logic          dat_oe;
		hpc_ids_t      shreg;
		logic          done;
	} hpc_rd_t;

	hpc_rd_t s;
	hpc_rd_t next_s;
	logic    half;

	// Every state except RD_IDLE advances on the half-period tick of the serial clock; RD_IDLE leaves on start.
	always_comb begin
		next_s      = s;
		next_s.d1   = mem_data_in;
		next_s.d2   = s.d1;
		next_s.done = 1'b0;
		half        = (s.tick >= 16'(HALF_CYC - 1));
		next_s.tick = half ? 16'h0000 : s.tick + 16'h0001;
		case (s.st)
			RD_IDLE: begin
				next_s.tick = 16'h0000;
				if (start) begin
					next_s.st     = RD_START;
					next_s.clk_o  = 1'b1;
					next_s.clk_oe = 1'b1;
					next_s.dat_o  = 1'b1;
					next_s.dat_oe = 1'b1;
					next_s.phase  = 2'h0;
				end
			end
			RD_START: if (half) begin
				// Data falls while the clock is high, then the clock drops.
				if (s.phase == 2'h0) begin
					next_s.dat_o = 1'b0;
					next_s.phase = 2'h1;
				end else begin
					next_s.clk_o  = 1'b0;
					next_s.dat_oe = 1'b0;
					next_s.nbit   = 6'h00;
					next_s.st     = RD_BITS;
				end
			end
			RD_BITS: if (half) begin
				next_s.clk_o = ~s.clk_o;
				if (s.clk_o) begin
					next_s.shreg = {s.shreg[CFG_BITS-2:0], s.d2};
					next_s.nbit  = s.nbit + 6'h01;
					if (s.nbit == 6'(CFG_BITS - 1)) begin
						next_s.st     = RD_STOP;
						next_s.dat_o  = 1'b0;
						next_s.dat_oe = 1'b1;
						next_s.phase  = 2'h0;
					end
				end
			end
			RD_STOP: if (half) begin
				if (s.phase == 2'h0) begin
					next_s.clk_o = 1'b1;
					next_s.phase = 2'h1;
				end else begin
					next_s.dat_o = 1'b1;
					next_s.st    = RD_END;
				end
			end
			RD_END: if (half) begin
				// Release both lines so another master may use the memory; the clock value is parked low too.
				next_s.clk_o  = 1'b0;
				next_s.clk_oe = 1'b0;
				next_s.dat_oe = 1'b0;
				next_s.done   = 1'b1;
				next_s.st     = RD_IDLE;
			end
			default: next_s.st = RD_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign mem_clock_out = s.clk_o;
	assign mem_clock_oe  = s.clk_oe;
	assign mem_data_out  = s.dat_o;
	assign mem_data_oe   = s.dat_oe;
	assign ids           = s.shreg;
	assign done          = s.done;

endmodule

// ==== hdl/hpc_hub_power.sv ====
// Downstream port power, strap and identifier control of a four-port hub with an AXI4-Lite register slave.
//
// Overview of operation
// - Gang mode: all four power enables switch together as one group.
// - Gang mode: any over-current turns every downstream port off.
// - Per-port mode: each enable and over-current input acts on its own port.
// - Memory disabled: report the built-in default product identifier.
// - Memory disabled: memory clock pin is off, shared data pin reads gang select.
// - Memory enabled: shared pins are memory clock and data, identifiers come from memory.
// - Memory clock is a three-state output so the memory can be shared.
// - Memory data is bidirectional in memory mode, input only otherwise.
// - Bus-powered select high means bus-powered, low means self-powered.
// - Detect full or low speed per port and set its slew rate to match.
// - Power enables are active low push-pull outputs, never open drain.
// - Over-current inputs are active low and glitch filtered before use.
// - Active-low reset at power-up initialises all internal logic.
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
module hpc_hub_power
	import hpc_pkg::*;
#(
	parameter int NP       = NPORTS,
	parameter int FILT_CYC = OC_FILTER_CYC,
	parameter int HALF_CYC = CFG_HALF_CYC
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite slave.
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   irq,
	// Straps and shared serial memory pins.
	input  wire logic              ext_config_mem_enable_n,
	input  wire logic              bus_powered_select,
	output logic                   cfg_mem_clock_o,
	output logic                   cfg_mem_clock_oe,
	input  wire logic              cfg_mem_data_i,
	output logic                   cfg_mem_data_o,
	output logic                   cfg_mem_data_oe,
	// Downstream port power and line state.
	output logic [NP-1:0]          port_power_enable_n,
	input  wire logic [NP-1:0]     overcurrent_n,
	input  wire logic [NP-1:0]     port_dp,
	input  wire logic [NP-1:0]     port_dm,
	output logic [NP-1:0]          port_slow_slew,
	output logic                   self_powered,
	output hpc_ids_t               ident
);

	// ==========================================================================
	// State
	// ==========================================================================
	typedef struct packed {
		logic [2:0]       strap_s1;
		logic [2:0]       strap_s2;
		logic [NP-1:0]    dp_s1;
		logic [NP-1:0]    dp_s2;
		logic [NP-1:0]    dm_s1;
		logic [NP-1:0]    dm_s2;
		logic [1:0]       settle;
		logic             strap_done;
		hpc_straps_t      straps;
		logic             cfg_start;
		logic             cfg_done;
		logic [NP-1:0]    req;
		logic [NP-1:0]    trip;
		logic [NP-1:0]    pwr_n;
		logic [NP-1:0]    attached;
		logic [NP-1:0]    low_speed;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic             irq;
		hpc_ids_t         ids;
		logic             self_pwr;
		logic             awready;
		logic             wready;
		logic [ADDR_W-1:0] aw_addr;
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             arready;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
	} hpc_state_t;

	hpc_state_t       s;
	hpc_state_t       next_s;
	logic [NP-1:0]    oc_active;
	logic [NP-1:0]    oc_rise;
	hpc_ids_t         mem_ids;
	logic             mem_done;
	logic             gang_oc;
	logic             gang_on;
	logic [IRQ_W-1:0] irq_evt;
	logic [IRQ_W-1:0] irq_clr;
	logic [31:0]      status;

	// Decodes a byte address onto one aligned register word.
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
		reg_hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
	endfunction

	// Write-strobe aware merge of a narrow field into the low byte lane.
	function automatic logic [IRQ_W-1:0] lane0(input logic [3:0] strb, input logic [31:0] data);
		lane0 = strb[0] ? data[IRQ_W-1:0] : '0;
	endfunction

	// ==========================================================================
	// Submodules
	// ==========================================================================
	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_oc
			hpc_oc_filter #(
				.FILT_CYC      (FILT_CYC)
			) u_filt (
				.aclk          (aclk),
				.aresetn       (aresetn),
				.overcurrent_n (overcurrent_n[gi]),
				.oc_active     (oc_active[gi]),
				.oc_rise       (oc_rise[gi])
			);
		end
	endgenerate

	// The reader only runs when the strap selected the serial memory.
	hpc_cfg_reader #(
		.HALF_CYC      (HALF_CYC)
	) u_reader (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.start         (s.cfg_start),
		.mem_data_in   (cfg_mem_data_i),
		.mem_clock_out (cfg_mem_clock_o),
		.mem_clock_oe  (cfg_mem_clock_oe),
		.mem_data_out  (cfg_mem_data_o),
		.mem_data_oe   (cfg_mem_data_oe),
		.ids           (mem_ids),
		.done          (mem_done)
	);

	// ==========================================================================
	// Status word seen by software
	// ==========================================================================
	always_comb begin
		status                                 = 32'h0000_0000;
		status[ST_PWR_LSB +: NPORTS]           = ~s.pwr_n;
		status[ST_TRIP_LSB +: NPORTS]          = s.trip;
		status[ST_ATT_LSB +: NPORTS]           = s.attached;
		status[ST_LS_LSB +: NPORTS]            = s.low_speed;
		status[ST_GANG]                        = s.straps.gang;
		status[ST_BUS_POWERED_SELECT]                      = s.straps.bus_pwr;
		status[ST_EXT_CONFIG_MEM_ENABLE_N_N]                    = s.straps.ext_mem_n;
		status[ST_CFG_DONE]                    = s.cfg_done;
	end

	// ==========================================================================
	// Next-state logic
	// ==========================================================================
	always_comb begin
		next_s           = s;
		next_s.cfg_start = 1'b0;
		irq_clr          = '0;

		// Pins from the board pass two flip-flops before any logic reads them.
		next_s.strap_s1  = {ext_config_mem_enable_n, cfg_mem_data_i, bus_powered_select};
		next_s.strap_s2  = s.strap_s1;
		next_s.dp_s1     = port_dp;
		next_s.dp_s2     = s.dp_s1;
		next_s.dm_s1     = port_dm;
		next_s.dm_s2     = s.dm_s1;

		// Straps are taken once, after the synchronisers have filled.
		if (!s.strap_done) begin
			if (s.settle == STRAP_SETTLE) begin
				next_s.strap_done       = 1'b1;
				next_s.straps.ext_mem_n = s.strap_s2[2];
				next_s.straps.bus_pwr   = s.strap_s2[0];
				// Memory mode frees the shared pin, so gang select falls back to per-port.
				next_s.straps.gang      = s.strap_s2[2] & s.strap_s2[1];
				next_s.cfg_start        = ~s.strap_s2[2];
				next_s.self_pwr         = ~s.strap_s2[0];
			end else begin
				next_s.settle = s.settle + 2'h1;
			end
		end

		// Identifier source follows the memory strap.
		if (s.strap_done && s.straps.ext_mem_n && !s.cfg_done) begin
			next_s.ids.vendor_identifier = DEFAULT_VID;
			next_s.ids.product_identifier = DEFAULT_PID;
			next_s.cfg_done = 1'b1;
		end
		if (mem_done) begin
			next_s.ids      = mem_ids;
			next_s.cfg_done = 1'b1;
		end

		// Line state of each port: idle J on D+ means full speed, on D- low speed.
		for (int i = 0; i < NP; i++) begin
			next_s.attached[i]  = s.dp_s2[i] ^ s.dm_s2[i];
			if (s.dp_s2[i] ^ s.dm_s2[i]) begin
				next_s.low_speed[i] = s.dm_s2[i];
			end
		end

		// Trip flags: a new over-current wins over a release in the same cycle.
		gang_oc = |oc_rise;
		for (int i = 0; i < NP; i++) begin
			if (s.straps.gang) begin
				if (!s.req[0]) begin
					next_s.trip[i] = 1'b0;
				end
				if (gang_oc) begin
					next_s.trip[i] = 1'b1;
				end
			end else begin
				if (!s.req[i]) begin
					next_s.trip[i] = 1'b0;
				end
				if (oc_rise[i]) begin
					next_s.trip[i] = 1'b1;
				end
			end
		end

		// Power enables, driven low to switch a port on, always actively driven.
		gang_on = s.req[0] & ~(|s.trip) & ~(|oc_active);
		for (int i = 0; i < NP; i++) begin
			if (!s.strap_done) begin
				next_s.pwr_n[i] = 1'b1;
			end else if (s.straps.gang) begin
				next_s.pwr_n[i] = ~gang_on;
			end else begin
				next_s.pwr_n[i] = ~(s.req[i] & ~s.trip[i] & ~oc_active[i]);
			end
		end

		// Write channel: address and data may arrive in either order.
		if (s.awready && awvalid) begin
			next_s.awready = 1'b0;
			next_s.aw_addr = awaddr;
		end
		if (s.wready && wvalid) begin
			next_s.wready = 1'b0;
			next_s.w_data = wdata;
			next_s.w_strb = wstrb;
		end
		if (!s.awready && !s.wready && !s.bvalid) begin
			next_s.bvalid = 1'b1;
			next_s.bresp  = RESP_OKAY;
			if (reg_hit(s.aw_addr, OFS_CTRL)) begin
				if (s.w_strb[0]) begin
					next_s.req = s.w_data[NP-1:0];
				end
			end else if (reg_hit(s.aw_addr, OFS_IRQ_STAT)) begin
				irq_clr = lane0(s.w_strb, s.w_data);
			end else if (reg_hit(s.aw_addr, OFS_IRQ_MASK)) begin
				if (s.w_strb[0]) begin
					next_s.irq_mask = s.w_data[IRQ_W-1:0];
				end
			end else if (!reg_hit(s.aw_addr, OFS_STATUS) && !reg_hit(s.aw_addr, OFS_IDS)) begin
				next_s.bresp = RESP_SLVERR;
			end
		end
		if (s.bvalid && bready) begin
			next_s.bvalid  = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready  = 1'b1;
		end

		// Read channel: one cycle from address to data.
		if (s.arready && arvalid) begin
			next_s.arready = 1'b0;
			next_s.rvalid  = 1'b1;
			next_s.rresp   = RESP_OKAY;
			next_s.rdata   = 32'h0000_0000;
			if (reg_hit(araddr, OFS_CTRL)) begin
				next_s.rdata[NP-1:0] = s.req;
			end else if (reg_hit(araddr, OFS_STATUS)) begin
				next_s.rdata = status;
			end else if (reg_hit(araddr, OFS_IRQ_STAT)) begin
				next_s.rdata[IRQ_W-1:0] = s.irq_stat;
			end else if (reg_hit(araddr, OFS_IRQ_MASK)) begin
				next_s.rdata[IRQ_W-1:0] = s.irq_mask;
			end else if (reg_hit(araddr, OFS_IDS)) begin
				next_s.rdata = {s.ids.vendor_identifier, s.ids.product_identifier};
			end else begin
				next_s.rresp = RESP_SLVERR;
			end
		end
		if (s.rvalid && rready) begin
			next_s.rvalid  = 1'b0;
			next_s.arready = 1'b1;
		end

		// Sticky events: over-current per port and identifier load complete.
		irq_evt                = '0;
		irq_evt[NP-1:0]        = oc_rise;
		irq_evt[IRQ_CFG_BIT]   = ~s.cfg_done & next_s.cfg_done;
		next_s.irq_stat        = (s.irq_stat & ~irq_clr) | irq_evt;
		next_s.irq             = |(next_s.irq_stat & next_s.irq_mask);
	end

	// ==========================================================================
	// Registers
	// ==========================================================================
	// Synchronous reset leaves all ports off and the bus ready to accept.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s         <= '0;
			s.pwr_n   <= '1;
			s.awready <= 1'b1;
			s.wready  <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	assign awready             = s.awready;
	assign wready              = s.wready;
	assign bvalid              = s.bvalid;
	assign bresp               = s.bresp;
	assign arready             = s.arready;
	assign rvalid              = s.rvalid;
	assign rdata               = s.rdata;
	assign rresp               = s.rresp;
	assign irq                 = s.irq;
	assign port_power_enable_n = s.pwr_n;
	assign port_slow_slew      = s.low_speed;
	assign self_powered        = s.self_pwr;
	assign ident               = s.ids;

endmodule

// ==== hdl/hpc_oc_filter.sv ====
// Over-current input synchroniser and glitch filter for one downstream port.
module hpc_oc_filter
	import hpc_pkg::*;
#(
	parameter int FILT_CYC = OC_FILTER_CYC
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic overcurrent_n,
	output logic      oc_active,
	output logic      oc_rise
);

	typedef struct packed {
		logic        s1;
		logic        s2;
		logic [15:0] count;
		logic        level;
		logic        rise;
	} hpc_filt_t;

	hpc_filt_t s;
	hpc_filt_t next_s;

	// A new level is accepted only after it has held for the whole filter time.
	always_comb begin
		next_s      = s;
		next_s.s1   = ~overcurrent_n;
		next_s.s2   = s.s1;
		next_s.rise = 1'b0;
		if (s.s2 == s.level) begin
			next_s.count = 16'h0000;
		end else if (s.count >= 16'(FILT_CYC - 1)) begin
			next_s.count = 16'h0000;
			next_s.level = s.s2;
			next_s.rise  = s.s2;
		end else begin
			next_s.count = s.count + 16'h0001;
		end
	end

	// Synchronous reset clears the filter to the idle level.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign oc_active = s.level;
	assign oc_rise   = s.rise;

endmodule

// ==== hdl/hpc_pkg.sv ====
// Shared constants, register map and carrier types of the hub port power block.
package hpc_pkg;

	// ==========================================================================
	// Geometry and bus
	// ==========================================================================
	localparam int          NPORTS       = 4;
	localparam int          ADDR_W       = 8;
	localparam int          IRQ_W        = 5;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ==========================================================================
	// Register offsets (byte addresses)
	// ==========================================================================
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_STATUS   = 8'h04;
	localparam logic [7:0]  OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0]  OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0]  OFS_IDS      = 8'h10;

	// ==========================================================================
	// Field positions of the status register and interrupt bits
	// ==========================================================================
	localparam int          ST_PWR_LSB   = 0;
	localparam int          ST_TRIP_LSB  = 4;
	localparam int          ST_ATT_LSB   = 8;
	localparam int          ST_LS_LSB    = 12;
	localparam int          ST_GANG      = 16;
	localparam int          ST_BUS_POWERED_SELECT    = 17;
	localparam int          ST_EXT_CONFIG_MEM_ENABLE_N_N  = 18;
	localparam int          ST_CFG_DONE  = 19;
	localparam int          IRQ_CFG_BIT  = 4;
	localparam int          IDS_VID_LSB  = 16;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int          CLK_PERIOD_NS   = 20;
	localparam int          OC_FILTER_NS    = 1000;
	localparam int          OC_FILTER_CYC   = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CFG_HALF_NS     = 5000;
	localparam int          CFG_HALF_CYC    = CFG_HALF_NS / CLK_PERIOD_NS;
	localparam logic [1:0]  STRAP_SETTLE    = 2'h3;
	localparam int          CFG_BITS        = 32;

	// Identifier values shown when no serial memory is used; values are arbitrary.
	localparam logic [15:0] DEFAULT_VID  = 16'h0001;
	localparam logic [15:0] DEFAULT_PID  = 16'h0002;

	// ==========================================================================
	// Carrier types
	// ==========================================================================
	typedef struct packed {
		logic ext_mem_n;
		logic gang;
		logic bus_pwr;
	} hpc_straps_t;

	typedef struct packed {
		logic [15:0] vendor_identifier;
		logic [15:0] product_identifier;
	} hpc_ids_t;

endpackage

// ==== sim/hpc_hub_power_checker.sv ====
// Port-level assertions of the hub port power block.
module hpc_hub_power_checker
	import hpc_pkg::*;
#(
	parameter int FILT_CYC = OC_FILTER_CYC
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              ext_config_mem_enable_n,
	input wire logic              bus_powered_select,
	input wire logic              cfg_mem_clock_o,
	input wire logic              cfg_mem_clock_oe,
	input wire logic              cfg_mem_data_i,
	input wire logic [NPORTS-1:0] port_power_enable_n,
	input wire logic [NPORTS-1:0] overcurrent_n,
	input wire logic              self_powered,
	input wire hpc_ids_t          ident
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====================
	// Helper counters
	// ====================
	logic [3:0] rel;
	int         run1;
	int         runa;
	// Cycles since reset release and unbroken fault lengths; six spare cycles cover sync and register delay.
	always_ff @(posedge aclk) begin
		rel <= !aresetn ? 4'h0 : ((rel == 4'hF) ? rel : rel + 4'h1);
		run1 <= overcurrent_n[1] ? 0 : run1 + 1;
		runa <= (&overcurrent_n) ? 0 : runa + 1;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_gang;
		ext_config_mem_enable_n && cfg_mem_data_i;
	endsequence
	// ====================
	// Assertions
	// ====================
	a_reset_off: assert property (disable iff (1'b0)
		!aresetn |=> port_power_enable_n == 4'hF) else $error("ports on after reset");
	a_gang_group: assert property (
		s_gang |-> port_power_enable_n inside {4'h0, 4'hF}) else $error("gang ports split");
	a_gang_trip: assert property (
		s_gang ##0 runa == FILT_CYC + 6 |-> port_power_enable_n == 4'hF) else $error("gang fault kept power");
	a_port_trip: assert property (
		run1 == FILT_CYC + 6 |-> port_power_enable_n[1]) else $error("port fault kept power");
	a_clock_idle: assert property (
		ext_config_mem_enable_n |-> !cfg_mem_clock_oe) else $error("memory clock driven");
	a_clock_driven: assert property (
		cfg_mem_clock_o |-> cfg_mem_clock_oe) else $error("clock high undriven");
	a_self_pwr: assert property (
		rel == 4'hC |-> self_powered == !bus_powered_select) else $error("power source wrong");
	a_strap_hold: assert property (
		rel == 4'hF |-> $stable(self_powered) && (!ext_config_mem_enable_n || $stable(ident)))
		else $error("strap setting moved");
	a_default_ids: assert property (
		ext_config_mem_enable_n && rel == 4'hC |-> ident == {DEFAULT_VID, DEFAULT_PID})
		else $error("default ids wrong");
endmodule
bind hpc_hub_power hpc_hub_power_checker #(.FILT_CYC(FILT_CYC)) u_chk (
	.aclk, .aresetn, .ext_config_mem_enable_n, .bus_powered_select, .cfg_mem_clock_o, .cfg_mem_clock_oe,
	.cfg_mem_data_i, .port_power_enable_n, .overcurrent_n, .self_powered, .ident
);

// ==== sim/hpc_hub_power_tb.sv ====
// Self-checking testbench of the hub port power block.
module hpc_hub_power_tb
	import hpc_pkg::*;
	();
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic e; logic g; logic b; logic [31:0] id;} hpc_row_t;
	localparam logic [31:0] MEM_WORD = 32'hA5C3_1E96; // Arbitrary identifiers held by the memory model.
	localparam hpc_row_t ROWS [3] = '{'{1'b0, 1'b0, 1'b1, MEM_WORD},
		'{1'b1, 1'b1, 1'b1, {DEFAULT_VID, DEFAULT_PID}}, '{1'b1, 1'b0, 1'b0, {DEFAULT_VID, DEFAULT_PID}}};
	logic        aclk, aresetn, awvalid, wvalid, arvalid, bvalid, arready, rvalid, irq, awready, wready;
	logic        ext_n, bus_sel, gang, mline, clk_o, clk_oe, dat_o, dat_oe, self_pwr;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [3:0]  pwr_n, oc_n, dp, dm, slow;
	hpc_ids_t    ident;
	int          fails = 0;
	int          n_tests = 0;
	// Ready lines stay high, so every response is taken at the edge it is offered.
	hpc_hub_power #(.FILT_CYC(4), .HALF_CYC(4)) u_dut (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid,
		.bready(1'b1), .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready(1'b1), .irq,
		.ext_config_mem_enable_n(ext_n), .bus_powered_select(bus_sel), .cfg_mem_clock_o(clk_o),
		.cfg_mem_clock_oe(clk_oe), .cfg_mem_data_i(ext_n ? gang : mline), .cfg_mem_data_o(dat_o),
		.cfg_mem_data_oe(dat_oe), .port_power_enable_n(pwr_n), .overcurrent_n(oc_n), .port_dp(dp),
		.port_dm(dm), .port_slow_slew(slow), .self_powered(self_pwr), .ident
	);
	hpc_mem_model #(.WORD(MEM_WORD)) u_mem (.clock_o(clk_o), .clock_oe(clk_oe), .data_o(dat_o),
		.data_oe(dat_oe), .line(mline));
	// ====================
	// Clock and tasks
	// ====================
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("Counts: %0d compares, %0d mismatches", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// A bus answer that never comes ends the run rather than hanging it.
	task automatic tmo(input int k);
		if (k >= 60) begin
			fails++;
			$display("Error at %0t ns: no bus answer", $time);
			end_of_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (k = 0; k < 60; k++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		tmo(k);
		chk(bresp, er);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		araddr <= a;
		arvalid <= 1'b1;
		for (k = 0; k < 60; k++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		tmo(k);
	endtask
	task automatic wt(input logic [3:0] e);
		int k;
		for (k = 0; k < 100 && pwr_n !== e; k++) @(posedge aclk);
		chk(pwr_n, e);
	endtask
	// Straps change only while reset is held.
	task automatic rst(input hpc_row_t rw);
		aresetn <= 1'b0;
		ext_n <= rw.e;
		gang <= rw.g;
		bus_sel <= rw.b;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask
	// ====================
	// Main sequence
	// ====================
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          k;
		{aresetn, awvalid, wvalid, arvalid, ext_n, bus_sel, gang} = 7'h0;
		{awaddr, araddr, wdata} = 48'h0;
		{oc_n, dp, dm} = 12'hF00;
		@(posedge aclk);
		for (int i = 0; i < 3; i++) begin
			rst(ROWS[i]);
			for (k = 0; k < 600; k++) begin
				rd(OFS_STATUS, d, r);
				if (d[ST_CFG_DONE]) break;
			end
			chk(ident, ROWS[i].id);
			chk(d[19:16], {1'b1, ROWS[i].e, ROWS[i].b, ROWS[i].g & ROWS[i].e});
			chk(self_pwr, !ROWS[i].b);
			chk({clk_oe, dat_oe, pwr_n}, 6'h0F);
			$display("Strap row %0d done", i);
		end
		// Per-port mode: a short glitch is ignored, a held fault trips only its own port.
		wr(OFS_IRQ_MASK, 32'hF, RESP_OKAY);
		wr(OFS_CTRL, 32'hF, RESP_OKAY);
		wt(4'h0);
		oc_n <= 4'hD;
		repeat (2) @(posedge aclk);
		oc_n <= 4'hF;
		repeat (20) @(posedge aclk);
		chk({irq, pwr_n}, 5'h00);
		oc_n <= 4'hD;
		wt(4'h2);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b1);
		oc_n <= 4'hF;
		rd(OFS_IRQ_STAT, d, r);
		chk(d[3:0], 4'h2);
		wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b0);
		wr(OFS_IRQ_STAT, 32'h1F, RESP_OKAY);
		wr(OFS_IRQ_MASK, 32'hF, RESP_OKAY);
		rd(OFS_IRQ_STAT, d, r);
		chk({irq, d[3:0]}, 5'h00);
		wr(OFS_CTRL, 32'hD, RESP_OKAY);
		wr(OFS_CTRL, 32'hF, RESP_OKAY);
		wt(4'h0);
		rd(8'h40, d, r);
		chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
		wr(8'h40, 32'h1, RESP_SLVERR);
		dm <= 4'h4;
		repeat (6) @(posedge aclk);
		chk(slow, 4'h4);
		{dp, dm} <= 8'h40;
		repeat (6) @(posedge aclk);
		chk(slow, 4'h0);
		$display("Per-port tests done");
		// Gang mode: a fault on one port removes power from all four.
		rst('{1'b1, 1'b1, 1'b0, 32'h0});
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		wt(4'h0);
		oc_n <= 4'h7;
		wt(4'hF);
		rd(OFS_STATUS, d, r);
		chk(d[7:4], 4'hF);
		repeat (8) @(posedge aclk);
		chk(pwr_n, 4'hF);
		$display("Gang tests done");
		end_of_test();
	end
endmodule

// ==== sim/hpc_mem_model.sv ====
// Behavioural serial configuration memory on the shared clock and data pins.
module hpc_mem_model #(
	parameter logic [31:0] WORD = 32'h0
) (
	input  wire logic clock_o,
	input  wire logic clock_oe,
	input  wire logic data_o,
	input  wire logic data_oe,
	output logic      line
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk;
	logic [5:0] cnt = 6'h0;
	// A released clock pin sits at its pull-down level.
	assign clk = clock_oe & clock_o;
	// A start or stop from the hub rewinds the pointer; each clock rise moves one bit out, MSB first.
	always @(posedge clk or posedge data_oe) begin
		if (data_oe) begin
			cnt <= 6'h0;
		end else if (cnt < 6'd32) begin
			cnt <= cnt + 6'h1;
		end
	end
	// The hub's drive wins, else the memory's bit, else the pull-down, so a stale bit never lingers.
	assign line = data_oe ? data_o : ((clock_oe && cnt != 6'h0) ? WORD[6'd32 - cnt] : 1'b0);
endmodule
